// ===== design/pti_desc_buffer.sv
// descriptor buffer: words appended in order, two read ports for word pairs
// assumes writes arrive only from the programming port of the injector
`timescale 1ns/1ps
module pti_desc_buffer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clear,
	// append side
	input wire logic wrEn,
	input wire logic [31:0] wrData,
	output logic full,
	output logic [pti_pkg::CNT_W-1:0] wordCount,
	// fetch side
	input wire logic [pti_pkg::PTR_W-1:0] rdAddr,
	output logic [31:0] rdWord0,
	output logic [31:0] rdWord1
);

	// ==========================================================
	// storage; contents need no reset, the count alone marks what is valid
	logic [31:0] mem [pti_pkg::BUF_DEPTH];
	logic [pti_pkg::CNT_W-1:0] count_r;
	logic [pti_pkg::PTR_W-1:0] rdAddr1;

	assign full = (count_r == pti_pkg::CNT_W'(pti_pkg::BUF_DEPTH));
	assign wordCount = count_r;
	assign rdAddr1 = rdAddr + pti_pkg::PTR_W'(1);
	assign rdWord0 = mem[rdAddr];
	assign rdWord1 = mem[rdAddr1];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_r <= '0;
		end else if (clear) begin
			count_r <= '0;
		end else if (wrEn && !full) begin
			count_r <= count_r + pti_pkg::CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (wrEn && !full && !clear) begin
			mem[count_r[pti_pkg::PTR_W-1:0]] <= wrData;
		end
	end

endmodule : pti_desc_buffer

// ===== design/pti_injector.sv
// programmable traffic injector: descriptor pipeline driving one manager port
// assumes a single clock shared by programming and injection ports
`timescale 1ns/1ps
module pti_injector (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// programming port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// injection port
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [2:0] hburst,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);

	// ==========================================================
	// state and descriptor buffer
	pti_pkg::pti_regs_t s, n;
	logic bufFull;
	logic [pti_pkg::CNT_W-1:0] bufCount;
	logic [31:0] word0;
	logic [31:0] word1;
	logic feedWr;
	logic clrReq;
	logic setupPh;
	logic [3:0] kind;
	logic [3:0] newKind;
	logic netEv;
	logic intEv;
	logic cmpEv;
	logic descEv;
	logic haltNow;
	logic canIssue;
	logic [31:0] cfgRd;
	logic [17:0] beatsWide;

	// read data is ignored: traffic is generated for its timing only
	logic unusedRd;
	assign unusedRd = ^hrdata;

	assign setupPh = psel && !penable;
	assign feedWr = setupPh && pwrite && (paddr == pti_pkg::OFS_FEED) && !bufFull;
	assign clrReq = setupPh && pwrite && (paddr == pti_pkg::OFS_CONFIG)
		&& pwdata[pti_pkg::CFG_SWCLEAR];
	assign kind = s.w0[pti_pkg::DW_KIND_LSB +: 4];
	assign newKind = word0[pti_pkg::DW_KIND_LSB +: 4];

	pti_desc_buffer u_buf (
		.clk_sys(clk_sys),
		.rst(rst),
		.clear(clrReq),
		.wrEn(feedWr),
		.wrData(pwdata),
		.full(bufFull),
		.wordCount(bufCount),
		.rdAddr(s.ptr),
		.rdWord0(word0),
		.rdWord1(word1)
	);

	// ==========================================================
	// configuration readback
	always_comb begin
		cfgRd = '0;
		cfgRd[pti_pkg::CFG_ENABLE] = s.en;
		cfgRd[pti_pkg::CFG_LOOP] = s.loop;
		cfgRd[pti_pkg::CFG_HALT_NET] = s.hNet;
		cfgRd[pti_pkg::CFG_HALT_INT] = s.hInt;
		cfgRd[pti_pkg::CFG_HALT_CMP] = s.hCmp;
		cfgRd[pti_pkg::CFG_RUNNING] = (s.st != pti_pkg::S_IDLE);
		cfgRd[pti_pkg::CFG_F_DESC] = s.fDesc;
		cfgRd[pti_pkg::CFG_F_NET] = s.fNet;
		cfgRd[pti_pkg::CFG_F_INT] = s.fInt;
		cfgRd[pti_pkg::CFG_F_CMP] = s.fCmp;
		cfgRd[pti_pkg::CFG_F_HALT] = s.fHalt;
		cfgRd[pti_pkg::CFG_COUNT_LSB +: pti_pkg::CNT_W] = bufCount;
	end

	// ==========================================================
	// events seen this cycle
	// first cycle of a two-cycle error answer
	assign netEv = s.dataPh && hresp && !hready;
	assign intEv = (s.st == pti_pkg::S_DECODE) && (kind != pti_pkg::K_WAIT)
		&& !pti_pkg::kindTraffic(kind);
	assign descEv = (s.st == pti_pkg::S_DONE) && (!s.dataPh || hready);
	assign cmpEv = descEv && (s.w0[pti_pkg::DW_FINAL] || (s.st == pti_pkg::S_DONE
		&& {1'b0, s.ptr} >= bufCount && s.ptr == '0 && bufCount == '0));
	assign haltNow = (netEv && s.hNet) || (intEv && s.hInt) || (cmpEv && s.hCmp);
	assign canIssue = (s.st == pti_pkg::S_RUN) && pti_pkg::kindTraffic(kind)
		&& (s.beats != '0) && !clrReq && !haltNow && !netEv;
	// two spare bits so a full 16-bit amount still rounds up to whole words
	assign beatsWide = 18'(s.w0[pti_pkg::DW_AMT_LSB +: 16]) + 18'h00003;

	// ==========================================================
	// next state
	always_comb begin
		n = s;
		n.pready = 1'b0;
		n.pslverr = 1'b0;

		// programming port, answered without wait states
		if (setupPh) begin
			n.pready = 1'b1;
			n.prdata = '0;
			if (paddr == pti_pkg::OFS_CONFIG) begin
				if (pwrite) begin
					n.en = pwdata[pti_pkg::CFG_ENABLE];
					n.loop = pwdata[pti_pkg::CFG_LOOP];
					n.hNet = pwdata[pti_pkg::CFG_HALT_NET];
					n.hInt = pwdata[pti_pkg::CFG_HALT_INT];
					n.hCmp = pwdata[pti_pkg::CFG_HALT_CMP];
					n.fDesc = s.fDesc && !pwdata[pti_pkg::CFG_F_DESC];
					n.fNet = s.fNet && !pwdata[pti_pkg::CFG_F_NET];
					n.fInt = s.fInt && !pwdata[pti_pkg::CFG_F_INT];
					n.fCmp = s.fCmp && !pwdata[pti_pkg::CFG_F_CMP];
					n.fHalt = s.fHalt && !pwdata[pti_pkg::CFG_F_HALT];
				end else begin
					n.prdata = cfgRd;
				end
			end else if (paddr == pti_pkg::OFS_FEED) begin
				n.pslverr = pwrite && bufFull;
			end else begin
				n.pslverr = 1'b1;
			end
		end

		// descriptor pipeline
		case (s.st)
			pti_pkg::S_IDLE: begin
				if (s.en) begin
					n.ptr = '0;
					n.st = pti_pkg::S_FETCH;
				end
			end
			pti_pkg::S_FETCH: begin
				if ({1'b0, s.ptr} >= bufCount) begin
					// ran past the loaded words: close the pattern
					n.w0 = pti_pkg::DESC_END_MARK;
					n.st = pti_pkg::S_DONE;
				end else begin
					n.w0 = word0;
					n.base = word1;
					if (pti_pkg::kindTraffic(newKind)) begin
						n.ptr = s.ptr + pti_pkg::PTR_W'(2);
					end else begin
						n.ptr = s.ptr + pti_pkg::PTR_W'(1);
					end
					n.st = pti_pkg::S_DECODE;
				end
			end
			pti_pkg::S_DECODE: begin
				n.rep = s.w0[pti_pkg::DW_REP_LSB +: 8];
				n.beats = beatsWide[17:2];
				n.wcnt = s.w0[pti_pkg::DW_AMT_LSB +: 16];
				n.addr = s.base;
				n.first = 1'b1;
				if (intEv) begin
					n.st = pti_pkg::S_DONE;
				end else begin
					n.st = pti_pkg::S_RUN;
				end
			end
			pti_pkg::S_RUN: begin
				if (pti_pkg::kindTraffic(kind)) begin
					if (canIssue && hready) begin
						n.beats = s.beats - 16'h0001;
						n.first = 1'b0;
						if (!pti_pkg::kindFixed(kind)) begin
							n.addr = s.addr + pti_pkg::ADDR_STEP;
						end
					end else if (s.beats == '0 && hready) begin
						if (s.rep != '0) begin
							n.rep = s.rep - 8'h01;
							n.beats = beatsWide[17:2];
							n.addr = s.base;
							n.first = 1'b1;
						end else begin
							n.st = pti_pkg::S_DONE;
						end
					end
				end else if (s.wcnt != '0) begin
					n.wcnt = s.wcnt - 16'h0001;
				end else if (s.rep != '0) begin
					n.rep = s.rep - 8'h01;
					n.wcnt = s.w0[pti_pkg::DW_AMT_LSB +: 16];
				end else begin
					n.st = pti_pkg::S_DONE;
				end
			end
			pti_pkg::S_DONE: begin
				// last data phase must end before the descriptor counts as done
				if (descEv) begin
					if (cmpEv) begin
						if (s.loop) begin
							n.ptr = '0;
							n.st = pti_pkg::S_FETCH;
						end else begin
							n.en = 1'b0;
							n.st = pti_pkg::S_IDLE;
						end
					end else begin
						n.st = pti_pkg::S_FETCH;
					end
				end
			end
			default: begin
				n.st = pti_pkg::S_IDLE;
			end
		endcase

		// software may stop a running pattern
		if (!n.en && s.st != pti_pkg::S_IDLE) begin
			n.st = pti_pkg::S_IDLE;
		end

		// halt wins over looping
		if (haltNow) begin
			n.en = 1'b0;
			n.st = pti_pkg::S_IDLE;
		end

		// manager port: address and data phases overlap for back-to-back beats
		if (netEv) begin
			// cancel the pending address phase during the error answer
			n.htrans = pti_pkg::TR_IDLE;
		end else if (hready) begin
			n.dataPh = (s.htrans != pti_pkg::TR_IDLE);
			if (s.htrans != pti_pkg::TR_IDLE && s.hwrite) begin
				n.hwdata = s.haddr;
			end
			if (canIssue) begin
				n.haddr = s.addr;
				n.hwrite = pti_pkg::kindWrite(kind);
				// bursts restart at 1 KB boundaries to stay legal
				if (s.first || pti_pkg::kindFixed(kind) || s.addr[9:0] == '0) begin
					n.htrans = pti_pkg::TR_NONSEQ;
				end else begin
					n.htrans = pti_pkg::TR_SEQ;
				end
				if (pti_pkg::kindFixed(kind)) begin
					n.hburst = pti_pkg::BURST_SINGLE;
				end else begin
					n.hburst = pti_pkg::BURST_INCR;
				end
			end else begin
				n.htrans = pti_pkg::TR_IDLE;
			end
		end

		// software clear: transfers already on the bus finish normally
		if (clrReq) begin
			n.st = pti_pkg::REGS_RST.st;
			n.ptr = '0;
			n.w0 = '0;
			n.rep = '0;
			n.beats = '0;
			n.wcnt = '0;
			n.en = 1'b0;
			n.loop = 1'b0;
			n.hNet = 1'b0;
			n.hInt = 1'b0;
			n.hCmp = 1'b0;
			n.fDesc = 1'b0;
			n.fNet = 1'b0;
			n.fInt = 1'b0;
			n.fCmp = 1'b0;
			n.fHalt = 1'b0;
		end

		// hardware events win over a clear in the same cycle
		if (descEv && s.w0[pti_pkg::DW_IRQ]) begin
			n.fDesc = 1'b1;
		end
		if (netEv) begin
			n.fNet = 1'b1;
		end
		if (intEv) begin
			n.fInt = 1'b1;
		end
		if (cmpEv) begin
			n.fCmp = 1'b1;
		end
		if (haltNow) begin
			n.fHalt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s <= pti_pkg::REGS_RST;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// outputs straight from state, hsize tied to SIZE_WORD
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign haddr = s.haddr;
	assign htrans = s.htrans;
	assign hwrite = s.hwrite;
	assign hsize = pti_pkg::SIZE_WORD;
	assign hburst = s.hburst;
	assign hwdata = s.hwdata;

endmodule : pti_injector

// ===== dv/pti_ahb_sub.sv
// ahb subordinate model facing the injector's manager port
// assumes one clock; the bench picks stalls and the error page
`timescale 1ns/1ps
module pti_ahb_sub (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// manager side
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	output logic hready,
	output logic hresp,
	output logic [31:0] hrdata,
	// bench control
	input wire logic stall,
	input wire logic [23:0] errPage
);
	logic dPh, dErr, eCyc;
	// ==========
	// two-cycle error response on the chosen page
	assign hresp = dPh && dErr;
	assign hready = !dPh || (dErr ? eCyc : !stall);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dPh <= 1'h0;
			dErr <= 1'h0;
			eCyc <= 1'h0;
			hrdata <= 32'h0;
		end else begin
			// read data never valid: negated every cycle, so it stays zero from reset
			hrdata <= ~hrdata + 32'h1;
			eCyc <= dPh && dErr && !eCyc;
			if (hready) begin
				dPh <= htrans[1];
				dErr <= haddr[31:8] == errPage;
			end
		end
	end
endmodule : pti_ahb_sub

// ===== dv/pti_injector_checker.sv
// assertions on the injector's programming and manager ports
// assumes binding into pti_injector; one clock domain
`timescale 1ns/1ps
module pti_injector_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// programming port
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// injection port
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic [2:0] hburst,
	input wire logic hready,
	input wire logic hresp
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic setup, act;
	assign setup = psel && !penable;
	assign act = htrans != pti_pkg::TR_IDLE;
	// ==========
	// programming port
	a_apb_ready: assert property (setup |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_unmapped_err: assert property (setup && paddr != pti_pkg::OFS_CONFIG
		&& paddr != pti_pkg::OFS_FEED |=> pready && pslverr)
		else $error("unmapped access not refused");
	a_cfg_no_err: assert property (setup && paddr == pti_pkg::OFS_CONFIG |=> !pslverr)
		else $error("config access refused");
	// ==========
	// manager port
	a_stall_hold: assert property (act && !hready && !hresp
		|=> $stable(haddr) && $stable(htrans) && $stable(hburst))
		else $error("address phase changed in stall");
	a_err_idle: assert property (hresp && !hready |=> htrans == pti_pkg::TR_IDLE)
		else $error("pending beat not dropped on error");
	a_word_size: assert property (act |-> hsize == pti_pkg::SIZE_WORD)
		else $error("bad transfer size");
	a_seq_step: assert property (htrans == pti_pkg::TR_SEQ && $past(hready)
		|-> haddr == $past(haddr) + pti_pkg::ADDR_STEP && hburst == pti_pkg::BURST_INCR)
		else $error("sequential beat not at next word");
	a_single_nseq: assert property (act && hburst == pti_pkg::BURST_SINGLE
		|-> htrans == pti_pkg::TR_NONSEQ)
		else $error("single beat not nonsequential");
	a_kb_nonseq: assert property (act && haddr[9:0] == 10'h0
		|-> htrans == pti_pkg::TR_NONSEQ)
		else $error("burst crosses 1KB boundary");
	c_seq: cover property (htrans == pti_pkg::TR_SEQ && hready);
	c_err: cover property (hresp && !hready);
	c_refuse: cover property (pready && pslverr);
	c_stall: cover property (act && !hready);
endmodule : pti_injector_checker
bind pti_injector pti_injector_checker chk (
	.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .haddr(haddr), .htrans(htrans),
	.hsize(hsize), .hburst(hburst), .hready(hready), .hresp(hresp)
);

// ===== dv/tb.sv
// self-checking bench for the traffic injector
// assumes pti_ahb_sub as far side and the bound checker
`timescale 1ns/1ps
module tb;
	logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
	logic hwrite, hready, hresp, stall, er, dpWr;
	logic [7:0] paddr, lfsr;
	logic [31:0] pwdata, prdata, haddr, hwdata, hrdata, rd, dpAddr, w;
	logic [1:0] htrans;
	logic [2:0] hsize, hburst;
	logic [23:0] errPage;
	logic [37:0] expQ[$];
	int error_cnt, n_checks, hits, cyc, nWords, n;
	pti_injector dut (
		.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hburst(hburst), .hwdata(hwdata),
		.hready(hready), .hresp(hresp), .hrdata(hrdata)
	);
	pti_ahb_sub sub (
		.clk_sys(clk_sys), .rst(rst), .haddr(haddr), .htrans(htrans),
		.hready(hready), .hresp(hresp), .hrdata(hrdata), .stall(stall),
		.errPage(errPage)
	);
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	// ==========
	// checks and verdict
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic chkReg(input logic [31:0] got, input logic [31:0] ex);
		n_checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, ex);
		end
	endtask : chkReg
	task automatic chkBeat(input logic [37:0] got);
		logic [37:0] ex;
		ex = 38'h0;
		if (expQ.size() > 0)
			ex = expQ.pop_front();
		n_checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, ex);
		end
	endtask : chkBeat
	// ==========
	// stimulus helpers
	function automatic logic [7:0] nextLfsr(input logic [7:0] v);
		nextLfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nextLfsr
	function automatic logic [31:0] dw(input logic [3:0] k, input logic [7:0] rep,
		input logic [15:0] amt, input logic irq, input logic fin);
		dw = {amt, rep, 2'h0, fin, k, irq};
	endfunction : dw
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(negedge clk_sys);
		psel = 1'h1;
		penable = 1'h0;
		pwrite = wr;
		paddr = a;
		pwdata = d;
		@(negedge clk_sys);
		penable = 1'h1;
		k = 0;
		@(posedge clk_sys);
		while (pready !== 1'h1 && k < 8) begin
			@(posedge clk_sys);
			k++;
		end
		rd = prdata;
		er = pslverr;
		@(negedge clk_sys);
		psel = 1'h0;
		penable = 1'h0;
	endtask : apb
	task automatic cfgWr(input logic [31:0] d);
		apb(1'h1, pti_pkg::OFS_CONFIG, d);
	endtask : cfgWr
	task automatic cfgRd;
		apb(1'h0, pti_pkg::OFS_CONFIG, 32'h0);
	endtask : cfgRd
	// reference model: expected address phases of one descriptor
	task automatic expPush(input logic [31:0] w0, input logic [31:0] a);
		logic [3:0] k;
		logic [31:0] ad;
		logic fx;
		int beats;
		k = w0[4:1];
		fx = k > 4'h2;
		beats = (int'(w0[31:16]) + 3) / 4;
		if (k >= 4'h1 && k <= 4'h4)
			for (int r = 0; r <= w0[15:8]; r++)
				for (int b = 0; b < beats; b++) begin
					ad = fx ? a : a + 32'(4 * b);
					expQ.push_back({ad, k == 4'h2 || k == 4'h4,
						(fx || b == 0 || ad[9:0] == 10'h0) ? pti_pkg::TR_NONSEQ : pti_pkg::TR_SEQ,
						fx ? pti_pkg::BURST_SINGLE : pti_pkg::BURST_INCR});
				end
	endtask : expPush
	task automatic addDesc(input logic [31:0] w0, input logic [31:0] a);
		apb(1'h1, pti_pkg::OFS_FEED, w0);
		nWords++;
		if (w0[4:1] >= 4'h1 && w0[4:1] <= 4'h4) begin
			apb(1'h1, pti_pkg::OFS_FEED, a);
			nWords++;
		end
		expPush(w0, a);
	endtask : addDesc
	task automatic waitIdle;
		int k;
		k = 0;
		rd = 32'h1;
		while (rd[0] !== 1'h0 && k < 400) begin
			cfgRd;
			k++;
		end
	endtask : waitIdle
	// ==========
	// far side stalls, watchdog and beat monitor
	always @(negedge clk_sys) begin
		lfsr <= nextLfsr(lfsr);
		stall <= lfsr[0] & lfsr[1];
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			give_verdict;
		end
		if (!rst && hready && dpWr)
			chkReg(hwdata, dpAddr);
		if (!rst && hready) begin
			dpWr = htrans[1] && hwrite;
			dpAddr = haddr;
		end
		if (!rst && hready && htrans[1]) begin
			hits++;
			chkBeat({haddr, hwrite, htrans, hburst});
		end
	end
	// ==========
	// main sequence
	initial begin
		rst = 1'h1;
		{psel, penable, pwrite, paddr, pwdata, stall, dpWr, dpAddr} = '0;
		errPage = 24'h80;
		lfsr = 8'h46;
		{error_cnt, n_checks, hits, cyc, nWords} = '0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'h0;
		cfgRd;
		chkReg(rd, 32'h0);
		chkReg({31'h0, er}, 32'h0);
		apb(1'h1, 8'h40, 32'hFFFF_FFFF);
		chkReg({31'h0, er}, 32'h1);
		cfgRd;
		chkReg(rd, 32'h0);
		// mixed pattern, stalls, error page, unsupported kind
		addDesc(dw(pti_pkg::K_FETCH, 8'h1, 16'h10, 1'h1, 1'h0), 32'h3F8);
		addDesc(dw(pti_pkg::K_STORE_FIX, 8'h2, 16'h8, 1'h0, 1'h0), 32'h1000);
		addDesc(dw(pti_pkg::K_WAIT, 8'h1, 16'h5, 1'h0, 1'h0), 32'h0);
		addDesc(dw(4'h7, 8'h0, 16'h4, 1'h0, 1'h0), 32'h0);
		addDesc(dw(pti_pkg::K_FETCH_FIX, 8'h0, 16'h4, 1'h0, 1'h0), 32'h8000);
		addDesc(dw(pti_pkg::K_STORE, 8'h0, 16'h8, 1'h0, 1'h1), 32'h2000);
		cfgRd;
		chkReg(rd, 32'(nWords) << 24);
		cfgWr(32'h1);
		waitIdle;
		chkReg(rd, 32'h0000_0F00 | (32'(nWords) << 24));
		chkReg(32'(expQ.size()), 32'h0);
		// flag clear, software clear, buffer refusal
		cfgWr(32'h0000_1F00);
		cfgRd;
		chkReg(rd, 32'(nWords) << 24);
		cfgWr(32'h2);
		cfgRd;
		chkReg(rd, 32'h0);
		for (int i = 0; i < 65; i++)
			apb(1'h1, pti_pkg::OFS_FEED, 32'h0);
		chkReg({31'h0, er}, 32'h1);
		cfgRd;
		chkReg(rd, 32'h4000_0000);
		// looping, then a network error halts it
		cfgWr(32'h2);
		nWords = 0;
		w = dw(pti_pkg::K_FETCH, 8'h0, 16'h4, 1'h0, 1'h1);
		addDesc(w, 32'h100);
		expPush(w, 32'h100);
		expPush(w, 32'h100);
		hits = 0;
		cfgWr(32'h0000_000D);
		n = 0;
		while (hits < 2 && n < 500) begin
			@(posedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
		errPage = 24'h1;
		waitIdle;
		chkReg(rd & 32'h0000_1207, 32'h0000_1204);
		chkReg(32'(expQ.size()), 32'h0);
		// halt on completion beats looping
		cfgWr(32'h2);
		errPage = 24'h80;
		addDesc(dw(pti_pkg::K_STORE_FIX, 8'h0, 16'h4, 1'h0, 1'h1), 32'h200);
		cfgWr(32'h0000_0025);
		waitIdle;
		chkReg(rd & 32'h0000_1807, 32'h0000_1804);
		chkReg(32'(expQ.size()), 32'h0);
		// hardware reset in mid-burst wipes the pattern and the bus
		cfgWr(32'h2);
		addDesc(dw(pti_pkg::K_FETCH, 8'h8, 16'h40, 1'h0, 1'h1), 32'h300);
		cfgWr(32'h0000_0005);
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'h1;
		dpWr = 1'h0;
		expQ.delete();
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'h0;
		chkReg({30'h0, htrans}, 32'h0);
		cfgRd;
		chkReg(rd, 32'h0);
		give_verdict;
	end
endmodule : tb

// ===== include/pti_pkg.sv
// constants, types and descriptor decoding shared by the traffic injector
// assumes one clock, an APB-style programming port and an AHB-style manager port
package pti_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_FEED = 8'hFC;

	// configuration register fields
	localparam int CFG_ENABLE = 0;
	localparam int CFG_SWCLEAR = 1;
	localparam int CFG_LOOP = 2;
	localparam int CFG_HALT_NET = 3;
	localparam int CFG_HALT_INT = 4;
	localparam int CFG_HALT_CMP = 5;
	localparam int CFG_RUNNING = 7;
	localparam int CFG_F_DESC = 8;
	localparam int CFG_F_NET = 9;
	localparam int CFG_F_INT = 10;
	localparam int CFG_F_CMP = 11;
	localparam int CFG_F_HALT = 12;
	localparam int CFG_COUNT_LSB = 24;

	// ==========================================================
	// descriptor buffer
	localparam int BUF_DEPTH = 64;
	localparam int PTR_W = 6;
	localparam int CNT_W = 7;

	// ==========================================================
	// first descriptor word
	localparam int DW_IRQ = 0;
	localparam int DW_KIND_LSB = 1;
	localparam int DW_FINAL = 5;
	localparam int DW_REP_LSB = 8;
	localparam int DW_AMT_LSB = 16;
	localparam logic [31:0] DESC_END_MARK = 32'h0000_0020;

	localparam logic [3:0] K_WAIT = 4'h0;
	localparam logic [3:0] K_FETCH = 4'h1;
	localparam logic [3:0] K_STORE = 4'h2;
	localparam logic [3:0] K_FETCH_FIX = 4'h3;
	localparam logic [3:0] K_STORE_FIX = 4'h4;

	// ==========================================================
	// manager port encodings
	localparam logic [1:0] TR_IDLE = 2'h0;
	localparam logic [1:0] TR_NONSEQ = 2'h2;
	localparam logic [1:0] TR_SEQ = 2'h3;
	localparam logic [2:0] BURST_SINGLE = 3'h0;
	localparam logic [2:0] BURST_INCR = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

	// ==========================================================
	// state
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_FETCH = 3'h1,
		S_DECODE = 3'h2,
		S_RUN = 3'h3,
		S_DONE = 3'h4
	} pti_state_t;

	typedef struct packed {
		pti_state_t st;
		logic [PTR_W-1:0] ptr;
		logic [31:0] w0;
		logic [31:0] base;
		logic [31:0] addr;
		logic [7:0] rep;
		logic [15:0] beats;
		logic [15:0] wcnt;
		logic first;
		logic en;
		logic loop;
		logic hNet;
		logic hInt;
		logic hCmp;
		logic fDesc;
		logic fNet;
		logic fInt;
		logic fCmp;
		logic fHalt;
		logic dataPh;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hburst;
		logic [31:0] hwdata;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pti_regs_t;

	localparam pti_regs_t REGS_RST = '0;

	// ==========================================================
	// descriptor kind decoding
	function automatic logic kindTraffic(input logic [3:0] k);
		kindTraffic = (k == K_FETCH) || (k == K_STORE) || (k == K_FETCH_FIX) || (k == K_STORE_FIX);
	endfunction : kindTraffic

	function automatic logic kindFixed(input logic [3:0] k);
		kindFixed = (k == K_FETCH_FIX) || (k == K_STORE_FIX);
	endfunction : kindFixed

	function automatic logic kindWrite(input logic [3:0] k);
		kindWrite = (k == K_STORE) || (k == K_STORE_FIX);
	endfunction : kindWrite

endpackage : pti_pkg
